/* File: core/stwl_device.sv */
`timescale 1ns/100ps
module stwl_device (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        clk_en,
  stwl_link_if.device      link,
  output logic [4:0]       cap_state_code,
  output logic             standby_select,
  output logic             latch_pulse
);
  logic [2:0] le_sync_q;
  logic [2:0] sck_sync_q;
  logic [1:0] sd_sync_q;
  logic [7:0] shift_q;
  logic       le_fall;
  logic       sck_rise;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      le_sync_q  <= 3'h0;
      sck_sync_q <= 3'h0;
      sd_sync_q  <= 2'h0;
    end else if (clk_en) begin
      le_sync_q  <= {le_sync_q[1:0], link.serial_latch_enable};
      sck_sync_q <= {sck_sync_q[1:0], link.shift_clk};
      sd_sync_q  <= {sd_sync_q[0], link.serial_data};
    end
  end

  // edges judged on synchronised stages 1 and 2 only
  assign sck_rise = sck_sync_q[1] & ~sck_sync_q[2];
  assign le_fall  = ~le_sync_q[1] & le_sync_q[2];

  // shift in msb first, no bit count, only while enabled
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      shift_q <= stwl_pkg::WORD_RESET;
    end else if (clk_en && sck_rise && le_sync_q[1]) begin
      shift_q <= {shift_q[stwl_pkg::WORD_W-2:0], sd_sync_q[1]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cap_state_code <= stwl_pkg::CODE_RESET;
      standby_select <= stwl_pkg::STANDBY_RESET;
      latch_pulse    <= 1'b0;
    end else if (clk_en) begin
      latch_pulse <= le_fall;
      if (le_fall) begin
        standby_select <= shift_q[stwl_pkg::STANDBY_BIT];
        cap_state_code <= shift_q[stwl_pkg::CODE_TOP_BIT:stwl_pkg::CODE_BOT_BIT];
      end
    end
  end
endmodule

/* File: core/stwl_link_if.sv */
`timescale 1ns/100ps
interface stwl_link_if;
  logic serial_latch_enable;
  logic shift_clk;
  logic serial_data;
  modport master (output serial_latch_enable, output shift_clk, output serial_data);
  modport device (input serial_latch_enable, input shift_clk, input serial_data);
endinterface

/* File: core/stwl_master.sv */
`timescale 1ns/100ps
module stwl_master (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        clk_en,
  stwl_link_if.master      link,
  input  wire logic        req_valid,
  input  wire logic [4:0]  req_code,
  input  wire logic        req_standby,
  output logic             req_ready,
  output logic             done
);
  stwl_pkg::stwl_state_t state_q;
  stwl_pkg::stwl_state_t state_d;
  logic [7:0]            word_q;
  logic [7:0]            word_d;
  logic [7:0]            tmr_q;
  logic [2:0]            bit_q;
  logic                  le_q;
  logic                  sck_q;
  logic                  sd_q;
  logic                  done_q;
  logic                  take;
  logic                  tmr_end;
  logic                  last_bit;
  logic                  enter_low;
  logic                  state_chg;

  // reserved bits always go out as zero
  function automatic logic [7:0] build_word(
    input logic       sb,
    input logic [4:0] code
  );
    logic [7:0] w;
    w = stwl_pkg::WORD_RESET;
    w[stwl_pkg::STANDBY_BIT] = sb;
    w[stwl_pkg::CODE_TOP_BIT:stwl_pkg::CODE_BOT_BIT] = code;
    return w;
  endfunction

  // latch enable stands high in every state of a frame
  function automatic logic in_frame(
    input stwl_pkg::stwl_state_t s
  );
    logic f;
    f = 1'b0;
    case (s)
      stwl_pkg::STWL_SETUP: f = 1'b1;
      stwl_pkg::STWL_LOW:   f = 1'b1;
      stwl_pkg::STWL_HIGH:  f = 1'b1;
      stwl_pkg::STWL_HOLD:  f = 1'b1;
      default:              f = 1'b0;
    endcase
    return f;
  endfunction

  // length of each phase in system clocks
  function automatic logic [7:0] phase_len(
    input stwl_pkg::stwl_state_t s
  );
    logic [7:0] n;
    n = stwl_pkg::DIV_HALF;
    case (s)
      stwl_pkg::STWL_SETUP: n = stwl_pkg::DIV_HALF;
      stwl_pkg::STWL_LOW:   n = stwl_pkg::DIV_HALF;
      stwl_pkg::STWL_HIGH:  n = stwl_pkg::DIV_HALF;
      stwl_pkg::STWL_HOLD:  n = stwl_pkg::DIV_HALF;
      stwl_pkg::STWL_GAP:   n = 8'(stwl_pkg::EOW_CYC);
      default:              n = stwl_pkg::DIV_HALF;
    endcase
    return n;
  endfunction

  // a new word is only taken while the link is idle
  assign req_ready = (state_q == stwl_pkg::STWL_IDLE);
  assign take      = req_valid & req_ready;
  assign tmr_end   = (tmr_q == '0);
  assign last_bit  = (bit_q == '0);
  assign enter_low = (state_d == stwl_pkg::STWL_LOW) && (state_q != stwl_pkg::STWL_LOW);
  assign state_chg = (state_d != state_q);

  assign done                     = done_q;
  assign link.serial_latch_enable = le_q;
  assign link.shift_clk           = sck_q;
  assign link.serial_data         = sd_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      stwl_pkg::STWL_IDLE: begin
        if (take) begin
          state_d = stwl_pkg::STWL_SETUP;
        end
      end
      stwl_pkg::STWL_SETUP: begin
        if (tmr_end) begin
          state_d = stwl_pkg::STWL_LOW;
        end
      end
      stwl_pkg::STWL_LOW: begin
        if (tmr_end) begin
          state_d = stwl_pkg::STWL_HIGH;
        end
      end
      stwl_pkg::STWL_HIGH: begin
        if (tmr_end && last_bit) begin
          state_d = stwl_pkg::STWL_HOLD;
        end else if (tmr_end) begin
          state_d = stwl_pkg::STWL_LOW;
        end
      end
      stwl_pkg::STWL_HOLD: begin
        if (tmr_end) begin
          state_d = stwl_pkg::STWL_GAP;
        end
      end
      stwl_pkg::STWL_GAP: begin
        if (tmr_end) begin
          state_d = stwl_pkg::STWL_IDLE;
        end
      end
      default: begin
        state_d = stwl_pkg::STWL_IDLE;
      end
    endcase
  end

  // word moves left once per high phase, next bit always in the top place
  always_comb begin
    word_d = word_q;
    if (take) begin
      word_d = build_word(req_standby, req_code);
    end else if ((state_q == stwl_pkg::STWL_HIGH) && tmr_end) begin
      word_d = {word_q[stwl_pkg::WORD_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= stwl_pkg::STWL_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // phase timer reloads on every change of state
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tmr_q <= '0;
    end else if (clk_en) begin
      if (state_chg) begin
        tmr_q <= phase_len(state_d) - 8'h01;
      end else if (!tmr_end) begin
        tmr_q <= tmr_q - 8'h01;
      end
    end
  end

  // bits still to send, eight per frame
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bit_q <= '0;
    end else if (clk_en) begin
      if (take) begin
        bit_q <= 3'(stwl_pkg::WORD_W - 1);
      end else if ((state_q == stwl_pkg::STWL_HIGH) && tmr_end && !last_bit) begin
        bit_q <= bit_q - 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      word_q <= stwl_pkg::WORD_RESET;
    end else if (clk_en) begin
      word_q <= word_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      le_q <= 1'b0;
    end else if (clk_en) begin
      le_q <= in_frame(state_d);
    end
  end

  // shift clock idles low and only runs inside a frame
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sck_q <= 1'b0;
    end else if (clk_en) begin
      sck_q <= (state_d == stwl_pkg::STWL_HIGH);
    end
  end

  // data changes only on entry to a low phase, and returns to zero outside a frame
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sd_q <= 1'b0;
    end else if (clk_en) begin
      if (enter_low) begin
        sd_q <= word_d[stwl_pkg::WORD_W-1];
      end else if (!in_frame(state_d)) begin
        sd_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      done_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= (state_q == stwl_pkg::STWL_GAP) && (state_d == stwl_pkg::STWL_IDLE);
    end
  end
endmodule

/* File: core/stwl_pkg.sv */
// Overview of operation
// - master raises latch enable before clocking
// - sample data on each shift clock rise
// - words go most significant bit first
// - master changes data on falling clock
// - latch word when latch enable falls
// - no bit count, keep last eight
// - ignore traffic while own enable low
// - shared enable: all update, reprogram all
// - master sends zeros in bits seven, six
// - bit five high selects standby
// - bits four to zero tuning code
// - enable held after last clock rise
// - enable low gap between transfers
// - code zero minimum, 31 maximum capacitance
// - allow wake time after leaving standby
package stwl_pkg;
  localparam int unsigned WORD_W        = 8;
  localparam int unsigned CODE_W        = 5;
  localparam int unsigned RSV_HI_BIT    = 7;
  localparam int unsigned RSV_LO_BIT    = 6;
  localparam int unsigned STANDBY_BIT   = 5;
  localparam int unsigned CODE_TOP_BIT  = 4;
  localparam int unsigned CODE_BOT_BIT  = 0;
  localparam int unsigned BIT_CNT_W     = 3;
  localparam logic [7:0]  WORD_RESET    = 8'h00;
  localparam logic [4:0]  CODE_RESET    = 5'h00;
  localparam logic        STANDBY_RESET = 1'b0;
  localparam int unsigned CLK_SYS_MHZ   = 20;
  localparam int unsigned CLK_PERIOD_NS = 1000 / CLK_SYS_MHZ;
  localparam real         EHD_NS        = 19.2;
  localparam real         EOW_NS        = 38.4;
  localparam real         SCL_LOW_NS    = 13.2;
  localparam real         SCL_HIGH_NS   = 13.2;
  localparam int unsigned WAKE_US       = 70;
  function automatic int unsigned ns_to_cyc(input real ns);
    int unsigned c;
    c = int'($ceil(ns / real'(CLK_PERIOD_NS)));
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned EHD_CYC       = ns_to_cyc(EHD_NS);
  localparam int unsigned EOW_CYC       = ns_to_cyc(EOW_NS);
  localparam int unsigned SCL_LOW_CYC   = ns_to_cyc(SCL_LOW_NS);
  localparam int unsigned SCL_HIGH_CYC  = ns_to_cyc(SCL_HIGH_NS);
  localparam int unsigned WAKE_CYC      = WAKE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TMR_W         = 8;
  localparam logic [7:0]  DIV_HALF      = 8'h04;
  typedef enum logic [2:0] {
    STWL_IDLE  = 3'b000,
    STWL_SETUP = 3'b001,
    STWL_LOW   = 3'b010,
    STWL_HIGH  = 3'b011,
    STWL_HOLD  = 3'b100,
    STWL_GAP   = 3'b101
  } stwl_state_t;
endpackage

/* File: verification/serial_tuning_word_loader_test.sv */
`timescale 1ns/100ps
module serial_tuning_word_loader_test;
  logic       clk_sys = 0, srst = 1, req_valid = 0, req_standby = 0;
  logic [4:0] req_code = 5'h00, cap_state_code, cap_code_b;
  logic       req_ready, done, standby_select, latch_pulse, standby_b, latch_b;
  logic [5:0] exp_q[$];
  logic [5:0] held = 6'h00;
  int         miscompares = 0, num_checks = 0, cyc = 0, num_done = 0, num_sent = 0;
  stwl_link_if link ();
  stwl_master stwl_master_inst (.clk_sys, .srst, .clk_en(1'b1), .link(link.master),
    .req_valid, .req_code, .req_standby, .req_ready, .done);
  stwl_device stwl_device_inst (.clk_sys, .srst, .clk_en(1'b1), .link(link.device),
    .cap_state_code, .standby_select, .latch_pulse);
  // second receiver on the same lines must update at the same enable fall
  stwl_device stwl_device_b_inst (.clk_sys, .srst, .clk_en(1'b1), .link(link.device),
    .cap_state_code(cap_code_b), .standby_select(standby_b), .latch_pulse(latch_b));
  stwl_monitor stwl_monitor_inst (.clk_sys, .srst, .serial_latch_enable(link.serial_latch_enable),
    .shift_clk(link.shift_clk), .serial_data(link.serial_data));
  always #25 clk_sys = ~clk_sys;
  task stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task send(input logic [5:0] w);
    @(posedge clk_sys) #1;
    req_valid = 1;
    {req_standby, req_code} = w;
    exp_q.push_back(w);
    num_sent++;
    while (req_ready !== 1'b1) @(posedge clk_sys) #1;
    @(posedge clk_sys) #1;
    req_valid = 0;
  endtask
  always @(posedge clk_sys) begin
    if (++cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  // outputs are looked at mid-cycle, where they have settled
  always @(negedge clk_sys) begin
    if (done === 1'b1) num_done++;
    if (srst === 1'b0 && latch_pulse !== 1'b1 && {standby_select, cap_state_code} !== held) begin
      miscompares++;
      $display("wrong value held word exp %h got %h", held, {standby_select, cap_state_code});
    end
    if (latch_pulse === 1'b1 && exp_q.size() == 0) begin
      miscompares++;
      $display("wrong value latch count exp 0 got 1");
    end else if (latch_pulse === 1'b1) begin
      num_checks++;
      if ({standby_select, cap_state_code} !== exp_q[0]) begin
        miscompares++;
        $display("wrong value latched word exp %h got %h", exp_q[0],
          {standby_select, cap_state_code});
      end
      void'(exp_q.pop_front());
      num_checks++;
      if ({standby_b, cap_code_b, latch_b} !== {standby_select, cap_state_code, 1'b1}) begin
        miscompares++;
        $display("wrong value shared enable exp %h got %h", {standby_select, cap_state_code},
          {standby_b, cap_code_b});
      end
    end
    held = {standby_select, cap_state_code};
  end
  initial begin
    void'($urandom(39));
    repeat (5) @(posedge clk_sys);
    #1 srst = 0;
    send(6'h00);
    send(6'h3f);
    send(6'h15);
    repeat (stwl_pkg::WAKE_CYC) @(posedge clk_sys);
    $display("test corners done");
    repeat (8) send(6'($urandom));
    while (exp_q.size() > 0) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    num_checks++;
    if (num_done != num_sent) begin
      miscompares++;
      $display("wrong value done count exp %0d got %0d", num_sent, num_done);
    end
    $display("test random done");
    stop_test();
  end
endmodule

/* File: verification/stwl_monitor.sv */
`timescale 1ns/100ps
module stwl_monitor (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic serial_latch_enable,
  input wire logic shift_clk,
  input wire logic serial_data
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  AST_RISE_IN_FRAME: assert property ($rose(shift_clk) |-> serial_latch_enable)
    else $error("shift clock rose outside a frame");
  AST_DATA_STEADY: assert property ($rose(shift_clk) |-> $stable(serial_data))
    else $error("data moved at a rising shift edge");
  AST_ENABLE_HOLD: assert property ($rose(shift_clk) |=> serial_latch_enable)
    else $error("enable dropped right after a rising edge");
  AST_ENABLE_GAP: assert property ($fell(serial_latch_enable) |=> !serial_latch_enable)
    else $error("enable gap too short");
  AST_CLOCK_LOW_AT_START: assert property ($rose(serial_latch_enable) |-> !shift_clk)
    else $error("shift clock high when frame opened");
  AST_CLOCK_IDLE_LOW: assert property (!serial_latch_enable |-> !shift_clk)
    else $error("shift clock ran outside a frame");
  cov_frame: cover property ($fell(serial_latch_enable));
  cov_one: cover property ($rose(shift_clk) && serial_data);
  cov_zero: cover property ($rose(shift_clk) && !serial_data);
endmodule
